// file: core/phy_status_summary.sv
// link status summary register with its management-interface read port
`timescale 1ns/1ps
`default_nettype none

// Contract
// - standby bit reads 1 in standby; no link attempt is made then.
// - role fault mirror always copies its source; reading never clears it.
// - parallel-detect fault mirror copies its source; reading never clears it.
// - negotiation-done mirror copies completion flag; reading never clears it.
// - pair swap flag reads 1 when pairs 0 and 1 were swapped.
// - 10 Mb polarity flag reads 1 when received polarity is inverted.
// - speed/duplex field shows resolved technology once link is up; 0x6 after reset.
// - speed codes: 5/4 gigabit full/half, 3/2 100 Mb, 1/0 10 Mb; 6,7 reserved.
// - link up flag follows link established state.
// - transmit enable mirror reads 1 while MAC transmit enable is asserted.
// - receive valid mirror reads 1 while receive data valid is asserted.
// - collision mirror reads 1 while collision is asserted.
// - both-ends-negotiate reads 1 only when both ends can negotiate.
// - partner pause flag matches partner pause capability.
// - partner asymmetric pause flag matches partner asymmetric capability.
// - register sits at address 0x1A and reads 0x0300 after reset.
module phy_status_summary
    import phy_status_summary_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR = PHY_ADDR_DEF
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // live status sources, same clock domain
    input  wire status_src_t status_src,
    // management interface pins
    input  wire logic        mdc,
    input  wire logic        mdio_i,
    output var  logic        mdio_o,
    output var  logic        mdio_oe_n,
    // status word and standby consequence
    output var  logic [15:0] status_word,
    output var  logic        link_attempt_en
);

    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    logic rst_s1_q;
    logic rst_sync_n;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_q   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_s1_q   <= 1'b1;
            rst_sync_n <= rst_s1_q;
        end
    end

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic mdc_s1_q;
    logic mdc_s2_q;
    logic mdc_s3_q;
    logic mdio_s1_q;
    logic mdio_s2_q;

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mdc_s1_q  <= 1'b0;
            mdc_s2_q  <= 1'b0;
            mdc_s3_q  <= 1'b0;
            mdio_s1_q <= 1'b1;
            mdio_s2_q <= 1'b1;
        end else begin
            mdc_s1_q  <= mdc;
            mdc_s2_q  <= mdc_s1_q;
            mdc_s3_q  <= mdc_s2_q;
            mdio_s1_q <= mdio_i;
            mdio_s2_q <= mdio_s1_q;
        end
    end

    wire logic mdc_rise = mdc_s2_q & ~mdc_s3_q;
    wire logic bit_in   = mdio_s2_q;

    // ------------------------------------------------------------------
    // status word assembly
    // ------------------------------------------------------------------
    function automatic logic speed_code_valid(input logic [2:0] code);
        speed_code_valid = (code <= SPD_1000_FD);
    endfunction

    logic [2:0]  speed_q;
    logic [2:0]  speed_d;
    logic [15:0] status_d;

    // code holds its reset value until a link has resolved; reserved codes are never latched
    assign speed_d = (status_src.link_up && speed_code_valid(status_src.resolved_speed_duplex))
                   ? status_src.resolved_speed_duplex : speed_q;

    always_comb begin
        status_d                            = 16'h0000;
        status_d[POS_STANDBY]               = status_src.standby_indicator;
        status_d[POS_ROLE_FAULT]            = status_src.role_resolution_fault;
        status_d[POS_PARDET_FAULT]          = status_src.parallel_detect_fault;
        status_d[POS_NEG_DONE]              = status_src.negotiation_complete;
        status_d[POS_PAIR_SWAP]             = status_src.pair_swap_fixed;
        status_d[POS_POL_FLIPPED]           = status_src.ten_meg_polarity_flipped;
        status_d[POS_SPEED_HI:POS_SPEED_LO] = speed_d;
        status_d[POS_LINK_UP]               = status_src.link_up;
        status_d[POS_TX_EN]                 = status_src.tx_en;
        status_d[POS_RX_DV]                 = status_src.rx_dv;
        status_d[POS_COLLISION]             = status_src.collision;
        status_d[POS_BOTH_NEG]              = status_src.local_neg_able
                                            & status_src.partner_neg_able;
        status_d[POS_PAUSE]                 = status_src.partner_pause_capability;
        status_d[POS_ASYM_PAUSE]            = status_src.partner_asym_capability;
    end

    // sources are only sampled, never written back, so no read can clear them
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            speed_q         <= SPD_RESET;
            status_word     <= STATUS_SUMMARY_RESET;
            link_attempt_en <= 1'b1;
        end else begin
            speed_q         <= speed_d;
            status_word     <= status_d;
            link_attempt_en <= ~status_src.standby_indicator;
        end
    end

    // ------------------------------------------------------------------
    // management frame receiver and read responder
    // ------------------------------------------------------------------
    mgmt_state_t state_q;
    logic [5:0]  pre_cnt_q;
    logic [3:0]  bit_cnt_q;
    logic [1:0]  op_q;
    logic [9:0]  addr_q;
    logic [15:0] shadow_q;

    wire logic [9:0] addr_next = {addr_q[8:0], bit_in};
    wire logic       pre_full  = (pre_cnt_q == PREAMBLE_BITS);
    // only a read of our own address at our phy address is answered
    wire logic       read_hit  = (op_q == OP_READ)
                               && (addr_q[9:5] == PHY_ADDR)
                               && (addr_q[4:0] == STATUS_SUMMARY_ADDR);

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_q   <= ST_PRE;
            pre_cnt_q <= 6'h00;
            bit_cnt_q <= 4'h0;
            op_q      <= 2'h0;
            addr_q    <= 10'h000;
            shadow_q  <= STATUS_SUMMARY_RESET;
            mdio_o    <= 1'b1;
            mdio_oe_n <= 1'b1;
        end else if (mdc_rise) begin
            case (state_q)
                ST_PRE: begin
                    if (bit_in) begin
                        pre_cnt_q <= pre_full ? pre_cnt_q : pre_cnt_q + 6'h01;
                    end else if (pre_full) begin
                        state_q <= ST_START;
                    end else begin
                        pre_cnt_q <= 6'h00;
                    end
                end
                ST_START: begin
                    state_q   <= bit_in ? ST_OP : ST_PRE;
                    pre_cnt_q <= 6'h00;
                    bit_cnt_q <= 4'h0;
                end
                ST_OP: begin
                    op_q      <= {op_q[0], bit_in};
                    bit_cnt_q <= bit_cnt_q + 4'h1;
                    if (bit_cnt_q == 4'h1) begin
                        state_q   <= ST_ADDR;
                        bit_cnt_q <= 4'h0;
                    end
                end
                ST_ADDR: begin
                    addr_q    <= addr_next;
                    bit_cnt_q <= bit_cnt_q + 4'h1;
                    if (bit_cnt_q == ADDR_BITS - 4'h1) begin
                        state_q   <= ST_TA;
                        bit_cnt_q <= 4'h0;
                        // snapshot so every bit of one read comes from the same cycle
                        shadow_q  <= status_word;
                    end
                end
                ST_TA: begin
                    bit_cnt_q <= bit_cnt_q + 4'h1;
                    if (bit_cnt_q == 4'h0) begin
                        mdio_o    <= 1'b0;
                        mdio_oe_n <= ~read_hit;
                    end else begin
                        mdio_o    <= shadow_q[15];
                        shadow_q  <= {shadow_q[14:0], 1'b0};
                        state_q   <= ST_DATA;
                        bit_cnt_q <= 4'h0;
                    end
                end
                ST_DATA: begin
                    // write data is clocked through and dropped
                    bit_cnt_q <= bit_cnt_q + 4'h1;
                    if (bit_cnt_q == DATA_LAST) begin
                        mdio_o    <= 1'b1;
                        mdio_oe_n <= 1'b1;
                        state_q   <= ST_WAIT;
                    end else begin
                        mdio_o    <= shadow_q[15];
                        shadow_q  <= {shadow_q[14:0], 1'b0};
                    end
                end
                ST_WAIT: begin
                    state_q   <= ST_PRE;
                    pre_cnt_q <= bit_in ? 6'h01 : 6'h00;
                end
                default: begin
                    state_q   <= ST_PRE;
                    pre_cnt_q <= 6'h00;
                    mdio_oe_n <= 1'b1;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// file: core/phy_status_summary_pkg.sv
// constants, field layout and types for the link status summary register
package phy_status_summary_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [4:0]  STATUS_SUMMARY_ADDR  = 5'h1A;
    localparam logic [15:0] STATUS_SUMMARY_RESET = 16'h0300;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int POS_STANDBY       = 15;
    localparam int POS_ROLE_FAULT    = 14;
    localparam int POS_PARDET_FAULT  = 13;
    localparam int POS_NEG_DONE      = 12;
    localparam int POS_PAIR_SWAP     = 11;
    localparam int POS_POL_FLIPPED   = 10;
    localparam int POS_SPEED_HI      = 9;
    localparam int POS_SPEED_LO      = 7;
    localparam int POS_LINK_UP       = 6;
    localparam int POS_TX_EN         = 5;
    localparam int POS_RX_DV         = 4;
    localparam int POS_COLLISION     = 3;
    localparam int POS_BOTH_NEG      = 2;
    localparam int POS_PAUSE         = 1;
    localparam int POS_ASYM_PAUSE    = 0;

    // ------------------------------------------------------------------
    // resolved speed/duplex codes
    // ------------------------------------------------------------------
    localparam logic [2:0] SPD_1000_FD   = 3'h5;
    localparam logic [2:0] SPD_1000_HD   = 3'h4;
    localparam logic [2:0] SPD_100_FD    = 3'h3;
    localparam logic [2:0] SPD_100_HD    = 3'h2;
    localparam logic [2:0] SPD_10_FD     = 3'h1;
    localparam logic [2:0] SPD_10_HD     = 3'h0;
    localparam logic [2:0] SPD_RESET     = 3'h6;

    // ------------------------------------------------------------------
    // management frame layout
    // ------------------------------------------------------------------
    localparam logic [5:0] PREAMBLE_BITS = 6'h20;
    localparam logic [3:0] ADDR_BITS     = 4'hA;
    localparam logic [3:0] DATA_LAST     = 4'hF;
    localparam logic [1:0] OP_READ       = 2'h2;
    localparam logic [1:0] OP_WRITE      = 2'h1;
    localparam logic [4:0] PHY_ADDR_DEF  = 5'h00;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       standby_indicator;
        logic       role_resolution_fault;
        logic       parallel_detect_fault;
        logic       negotiation_complete;
        logic       pair_swap_fixed;
        logic       ten_meg_polarity_flipped;
        logic [2:0] resolved_speed_duplex;
        logic       link_up;
        logic       tx_en;
        logic       rx_dv;
        logic       collision;
        logic       local_neg_able;
        logic       partner_neg_able;
        logic       partner_pause_capability;
        logic       partner_asym_capability;
    } status_src_t;

    typedef enum logic [6:0] {
        ST_PRE   = 7'b000_0001,
        ST_START = 7'b000_0010,
        ST_OP    = 7'b000_0100,
        ST_ADDR  = 7'b000_1000,
        ST_TA    = 7'b001_0000,
        ST_DATA  = 7'b010_0000,
        ST_WAIT  = 7'b100_0000
    } mgmt_state_t;

endpackage

// file: sim/phy_status_summary_props.sv
// assertion checker for the link status summary register
`timescale 1ns/1ps
`default_nettype none
module phy_status_summary_props
    import phy_status_summary_pkg::*;
(
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        rst_n,
    // watched ports
    input wire status_src_t status_src,
    input wire logic [15:0] status_word,
    input wire logic        link_attempt_en,
    input wire logic        mdc,
    input wire logic        mdio_o,
    input wire logic        mdio_oe_n
);
    // the internal reset lags the pin, so tracking checks wait three edges
    logic [1:0] up_q;
    logic       up;
    logic       take;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) up_q <= 2'h0;
        else if (!up) up_q <= up_q + 2'h1;
    end
    assign up   = (up_q == 2'h3);
    assign take = status_src.link_up && (status_src.resolved_speed_duplex <= SPD_1000_FD);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence drive_zero; !mdio_oe_n && !mdio_o; endsequence
    sequence drive_hold; !mdio_oe_n [*8]; endsequence
    reset_value_a: assert property (up_q == 2'h1 |->
        status_word == STATUS_SUMMARY_RESET && link_attempt_en) else $error("bad reset word");
    standby_bit_a: assert property (up |->
        status_word[15] == $past(status_src[16]) && link_attempt_en == !status_word[15])
        else $error("standby mismatch");
    fault_mirror_a: assert property (up |->
        status_word[14:10] == $past(status_src[15:11])) else $error("flag mirror mismatch");
    speed_update_a: assert property (up && $past(take) |->
        status_word[9:7] == $past(status_src[10:8])) else $error("speed not taken");
    speed_hold_a: assert property (up && !$past(take) |->
        $stable(status_word[9:7])) else $error("refused speed changed");
    live_mirror_a: assert property (up |->
        status_word[6:3] == $past(status_src[7:4])) else $error("live mirror mismatch");
    both_negotiate_a: assert property (up |->
        status_word[2] == $past(status_src[3] & status_src[2])) else $error("negotiate wrong");
    pause_flags_a: assert property (up |->
        status_word[1:0] == $past(status_src[1:0])) else $error("pause flags wrong");
    read_drive_a: assert property ($fell(mdio_oe_n) |->
        drive_zero ##1 drive_hold) else $error("read answer not held");
    read_release_a: assert property ($rose(mdio_oe_n) |->
        mdio_o) else $error("pin released low");
    // the pin copy passes two flops and an edge flop, so a drive change trails mdc by three
    edge_timing_a: assert property ($changed(mdio_oe_n) |->
        $past(mdc, 3)) else $error("drive change not after clock rise");
endmodule
bind phy_status_summary phy_status_summary_props u_props (
    .clk_sys(clk_sys), .rst_n(rst_n), .status_src(status_src), .status_word(status_word),
    .link_attempt_en(link_attempt_en), .mdc(mdc), .mdio_o(mdio_o),
    .mdio_oe_n(mdio_oe_n)
);
`default_nettype wire

// file: sim/mgmt_station.sv
// management station model that clocks frames onto the shared data pin
`timescale 1ns/1ps
`default_nettype none
module mgmt_station
    import phy_status_summary_pkg::*;
(
    // clock
    input  wire logic clk_sys,
    // pins; a released pin reads high through the pull-up
    output var  logic mdc,
    output var  logic drv_oe,
    output var  logic drv_val,
    input  wire logic line
);
    // six clocks a half period keeps the device's edge detector comfortable
    localparam int HALF = 6;
    initial {mdc, drv_oe, drv_val} = 3'h1;
    task automatic clk_bit(input logic oe, input logic b, output logic smp);
        @(posedge clk_sys);
        drv_oe  <= oe;
        drv_val <= b;
        repeat (HALF) @(posedge clk_sys);
        smp = line;
        mdc <= 1'b1;
        repeat (HALF) @(posedge clk_sys);
        mdc <= 1'b0;
    endtask
    // reads release the pin from the turnaround on; mdc rests low between frames
    task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [63:0] bits;
        logic        smp;
        bits = {32'hFFFF_FFFF, 2'h1, op, pa, ra, 2'h2, wd};
        for (int i = 63; i >= 0; i--) begin
            clk_bit(i > 17 || op == OP_WRITE, bits[i], smp);
            rd = {rd[14:0], smp};
        end
        clk_bit(1'b0, 1'b1, smp);
    endtask
endmodule
`default_nettype wire

// file: sim/phy_status_summary_test.sv
// self-checking bench for the link status summary register
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module phy_status_summary_test
    import phy_status_summary_pkg::*;
;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        sw_due = 1'b0;
    logic        rd_due = 1'b0;
    logic        mdc, st_oe, st_val, mdio_line, mdio_o, mdio_oe_n, lae;
    logic [2:0]  spd = SPD_RESET;
    logic [15:0] status_word, rd_word;
    logic [16:0] exp_q[$];
    logic [16:0] g, e, w;
    status_src_t src = '0;
    status_src_t s = '0;
    int          checks = 0;
    int          error_cnt = 0;
    always #2.5 clk_sys = ~clk_sys;
    assign mdio_line = st_oe ? st_val : (mdio_oe_n ? 1'b1 : mdio_o);
    phy_status_summary uut (
        .clk_sys(clk_sys), .rst_n(rst_n), .status_src(src), .mdc(mdc), .mdio_i(mdio_line),
        .mdio_o(mdio_o), .mdio_oe_n(mdio_oe_n), .status_word(status_word), .link_attempt_en(lae)
    );
    mgmt_station st (
        .clk_sys(clk_sys), .mdc(mdc), .drv_oe(st_oe), .drv_val(st_val), .line(mdio_line)
    );
    // expected {link attempt, word}; refused speed codes keep the held one
    function automatic logic [16:0] model(status_src_t x);
        if (x.link_up && x.resolved_speed_duplex <= SPD_1000_FD) spd = x.resolved_speed_duplex;
        return {!x[16], x[16:11], spd, x[7:4], x[3] & x[2], x[1:0]};
    endfunction
    task automatic apply(input status_src_t x);
        src <= x;
        @(posedge clk_sys);
        exp_q.push_back(model(x));
        sw_due = 1'b1;
        @(posedge clk_sys);
    endtask
    task automatic mgmt(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                        input logic [15:0] wd, input logic [15:0] ex);
        if (op == OP_READ) exp_q.push_back({1'b0, ex});
        st.frame(op, pa, ra, wd, rd_word);
        rd_due = (op == OP_READ);
    endtask
    always @(negedge clk_sys) if (sw_due) begin
        sw_due = 1'b0;
        g = {lae, status_word};
        e = exp_q.pop_front();
        `CHK(g[16:10], e[16:10])
        `CHK(g[9:7], e[9:7])
        `CHK(g[6:0], e[6:0])
    end
    always @(negedge clk_sys) if (rd_due) begin
        rd_due = 1'b0;
        e = exp_q.pop_front();
        `CHK(rd_word, e[15:0])
    end
    task automatic conclude();
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk_sys);
        error_cnt++;
        conclude();
    end
    initial begin
        void'($urandom(70));
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        apply(s);
        mgmt(OP_READ, PHY_ADDR_DEF, STATUS_SUMMARY_ADDR, 16'h0000, STATUS_SUMMARY_RESET);
        $display("reset test done");
        // all eight codes with link up, then a valid code while the link is down
        s.link_up = 1'b1;
        for (int c = 0; c < 8; c++) begin
            s.resolved_speed_duplex = 3'(c);
            apply(s);
        end
        s.link_up = 1'b0;
        s.resolved_speed_duplex = SPD_100_HD;
        apply(s);
        $display("speed test done");
        for (int i = 0; i < 300; i++) begin
            s = 17'($urandom);
            apply(s);
        end
        $display("random test done");
        // every op code; only a read answers and a write leaves the word alone
        w = model(s);
        for (int k = 0; k < 4; k++) begin
            mgmt(2'(k), PHY_ADDR_DEF, STATUS_SUMMARY_ADDR, ~w[15:0], w[15:0]);
        end
        // another register and another phy address must both leave the pin to the pull-up
        mgmt(OP_READ, PHY_ADDR_DEF, STATUS_SUMMARY_ADDR + 5'h01, 16'h0000, 16'hFFFF);
        mgmt(OP_READ, PHY_ADDR_DEF + 5'h01, STATUS_SUMMARY_ADDR, 16'h0000, 16'hFFFF);
        mgmt(OP_READ, PHY_ADDR_DEF, STATUS_SUMMARY_ADDR, 16'h0000, w[15:0]);
        $display("management test done");
        repeat (2) @(posedge clk_sys);
        conclude();
    end
endmodule
`default_nettype wire
